// >>> inc/pie_pkg.sv
/*
 * Constants, carrier types and helpers of the peripheral interrupt
 * enable and priority bank.
 * Assumes an 8-bit APB byte address and 32-bit APB data.
 */
`default_nettype none
package pie_pkg;
	localparam int unsigned PIE_NREG = 3;
	localparam int unsigned PIE_NSRC = 24;
	// byte addresses of the register words
	localparam logic [7:0] PIE_OFF_EN1  = 8'h00;
	localparam logic [7:0] PIE_OFF_EN2  = 8'h04;
	localparam logic [7:0] PIE_OFF_EN3  = 8'h08;
	localparam logic [7:0] PIE_OFF_PR1  = 8'h0c;
	localparam logic [7:0] PIE_OFF_PR2  = 8'h10;
	localparam logic [7:0] PIE_OFF_PR3  = 8'h14;
	localparam logic [7:0] PIE_OFF_FL1  = 8'h18;
	localparam logic [7:0] PIE_OFF_FL2  = 8'h1c;
	localparam logic [7:0] PIE_OFF_FL3  = 8'h20;
	localparam logic [7:0] PIE_OFF_CTRL = 8'h24;
	// values after reset
	localparam logic [7:0] PIE_RST_EN1  = 8'h00;
	localparam logic [7:0] PIE_RST_EN2  = 8'h00;
	localparam logic [7:0] PIE_RST_EN3  = 8'hff;
	localparam logic [7:0] PIE_RST_PR   = 8'hff;
	localparam logic [7:0] PIE_RST_FL   = 8'h00;
	localparam logic [2:0] PIE_RST_CTRL = 3'h0;
	// implemented bit positions, full and small package
	localparam logic [7:0] PIE_MASK1_FULL  = 8'hff;
	localparam logic [7:0] PIE_MASK1_SMALL = 8'h7f;
	localparam logic [7:0] PIE_MASK2_FULL  = 8'h5f;
	localparam logic [7:0] PIE_MASK2_SMALL = 8'h1e;
	localparam logic [7:0] PIE_MASK3       = 8'hff;
	// control word field positions
	localparam int unsigned PIE_CTRL_PRIO   = 0;
	localparam int unsigned PIE_CTRL_PERIPH = 1;
	localparam int unsigned PIE_CTRL_GLOBAL = 2;

	typedef struct packed
	{
		logic global_irq_enable;
		logic peripheral_group_enable;
		logic priority_levels_enable;
	} pie_ctrl_s;

	typedef struct packed
	{
		logic high;
		logic low;
	} pie_req_s;

	function automatic logic [7:0] pie_impl_mask(
		input logic [1:0] idx,
		input logic       small_pkg
	);
		logic [7:0] m;
		m = PIE_MASK3;
		case (idx)
			2'd0:    m = small_pkg ? PIE_MASK1_SMALL : PIE_MASK1_FULL;
			2'd1:    m = small_pkg ? PIE_MASK2_SMALL : PIE_MASK2_FULL;
			default: m = PIE_MASK3;
		endcase
		return m;
	endfunction : pie_impl_mask
endpackage : pie_pkg
`default_nettype wire

// >>> rtl/pie_irq_unit.sv
/*
 * Peripheral interrupt enable / priority bank with sticky source flags,
 * an APB register port and steering to high and low request levels.
 * Assumes peripheral event pulses and the APB master run on pclk.
 */
// Chosen here: the APB slave port and the placing of the registers.
// Overview of operation
// - with priority levels off, a source requests only if the group enable is set too.
// - priority bits steer requests only while priority levels are enabled.
// - a priority bit of 1 routes its source high, 0 routes it low.
// - enable word 1 holds parallel port down to timer1 overflow, bit 7 to 0.
// - enable word 2 holds comparator, eeprom, collision, low voltage, timer3, ecap.
// - enable word 3 holds the CAN sources, invalid message at 7 to rx buffer 0 at 0.
// - unimplemented bits of word 2 ignore writes and read zero.
// - the small package drops parallel port, comparator and ecap bits, reading zero.
// - enable words 1 and 2 reset to zero, the CAN enable word resets to all ones.
// - priority word 1 mirrors enable word 1, implemented bits reset to one.
// - priority word 2 mirrors enable word 2, implemented bits reset to one.
// - priority word 3 mirrors the CAN enable order and resets to all ones.
// - flags set on their event whatever the enables hold.
`default_nettype none
module pie_irq_unit
	import pie_pkg::*;
#(
	parameter bit SMALL_PKG = 1'b0
)
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	input  wire logic [pie_pkg::PIE_NSRC-1:0] src_event,
	output pie_pkg::pie_req_s               irq_req,
	output logic                            irq
);
	import pie_pkg::*;

	localparam logic [7:0] M1 = pie_impl_mask(2'd0, SMALL_PKG);
	localparam logic [7:0] M2 = pie_impl_mask(2'd1, SMALL_PKG);
	localparam logic [7:0] M3 = pie_impl_mask(2'd2, SMALL_PKG);

	logic [7:0]  en   [PIE_NREG];
	logic [7:0]  pr   [PIE_NREG];
	logic [7:0]  fl   [PIE_NREG];
	pie_ctrl_s   ctrl;
	logic [7:0]  msk  [PIE_NREG];
	logic        wr_acc;
	logic        setup;
	logic        hit;
	logic [31:0] next_rdata;
	logic [23:0] act;
	logic [23:0] pend;
	logic [23:0] prio;
	pie_req_s    next_req;
	logic        next_irq;

	assign msk[0] = M1;
	assign msk[1] = M2;
	assign msk[2] = M3;

	// zero-wait slave: every access phase completes at once
	assign pready = 1'b1;
	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite;

	function automatic logic mapped(input logic [7:0] a);
		return a inside {PIE_OFF_EN1, PIE_OFF_EN2, PIE_OFF_EN3,
			PIE_OFF_PR1, PIE_OFF_PR2, PIE_OFF_PR3,
			PIE_OFF_FL1, PIE_OFF_FL2, PIE_OFF_FL3, PIE_OFF_CTRL};
	endfunction : mapped

	assign hit     = mapped(paddr);
	assign pslverr = psel && penable && !hit;

	// enable words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en[0] <= PIE_RST_EN1;
			en[1] <= PIE_RST_EN2;
			en[2] <= PIE_RST_EN3;
		end
		else if (wr_acc)
		begin
			case (paddr)
				PIE_OFF_EN1: en[0] <= pwdata[7:0] & M1;
				PIE_OFF_EN2: en[1] <= pwdata[7:0] & M2;
				PIE_OFF_EN3: en[2] <= pwdata[7:0] & M3;
				default:     ;
			endcase
		end
	end

	// priority words; reset values already trimmed to implemented bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pr[0] <= PIE_RST_PR & M1;
			pr[1] <= PIE_RST_PR & M2;
			pr[2] <= PIE_RST_PR & M3;
		end
		else if (wr_acc)
		begin
			case (paddr)
				PIE_OFF_PR1: pr[0] <= pwdata[7:0] & M1;
				PIE_OFF_PR2: pr[1] <= pwdata[7:0] & M2;
				PIE_OFF_PR3: pr[2] <= pwdata[7:0] & M3;
				default:     ;
			endcase
		end
	end

	// control word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= pie_ctrl_s'(PIE_RST_CTRL);
		else if (wr_acc && paddr == PIE_OFF_CTRL)
		begin
			ctrl.priority_levels_enable  <= pwdata[PIE_CTRL_PRIO];
			ctrl.peripheral_group_enable <= pwdata[PIE_CTRL_PERIPH];
			ctrl.global_irq_enable       <= pwdata[PIE_CTRL_GLOBAL];
		end
	end

	// sticky flags, write one to clear; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < PIE_NREG; i++)
				fl[i] <= PIE_RST_FL;
		end
		else
		begin
			for (int i = 0; i < PIE_NREG; i++)
			begin
				if (wr_acc && paddr == PIE_OFF_FL1 + 8'(4 * i))
					fl[i] <= ((fl[i] & ~pwdata[7:0]) | src_event[8*i +: 8]) & msk[i];
				else
					fl[i] <= (fl[i] | src_event[8*i +: 8]) & msk[i];
			end
		end
	end

	assign act  = {fl[2] & en[2], fl[1] & en[1], fl[0] & en[0]};
	assign prio = {pr[2], pr[1], pr[0]};
	assign pend = {fl[2], fl[1], fl[0]};

	// steering to the sequencer levels
	always_comb
	begin
		next_req = '0;
		if (!ctrl.priority_levels_enable)
		begin
			// compatibility: one level, priority bits unused
			next_req.high = ctrl.global_irq_enable
				&& ctrl.peripheral_group_enable && |act;
		end
		else
		begin
			next_req.high = ctrl.global_irq_enable && |(act & prio);
			// low level needs both the global and the low-level enable
			next_req.low  = ctrl.global_irq_enable
				&& ctrl.peripheral_group_enable
				&& |(act & ~prio);
		end
	end

	// summary line ignores the gates so polling software can still wait on it
	assign next_irq = |act;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_req <= '0;
			irq     <= 1'b0;
		end
		else
		begin
			irq_req <= next_req;
			irq     <= next_irq;
		end
	end

	// read data is latched in the setup phase so it is stable in access
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			PIE_OFF_EN1:  next_rdata[7:0] = en[0];
			PIE_OFF_EN2:  next_rdata[7:0] = en[1];
			PIE_OFF_EN3:  next_rdata[7:0] = en[2];
			PIE_OFF_PR1:  next_rdata[7:0] = pr[0];
			PIE_OFF_PR2:  next_rdata[7:0] = pr[1];
			PIE_OFF_PR3:  next_rdata[7:0] = pr[2];
			PIE_OFF_FL1:  next_rdata[7:0] = fl[0];
			PIE_OFF_FL2:  next_rdata[7:0] = fl[1];
			PIE_OFF_FL3:  next_rdata[7:0] = fl[2];
			PIE_OFF_CTRL: next_rdata[2:0] = ctrl;
			default:      next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= next_rdata;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// unimplemented positions never hold a one
	unimpl_bits_zero_a: assert property (
		((en[1] | pr[1]) & ~M2) == 8'h00 && ((en[0] | pr[0]) & ~M1) == 8'h00)
		else $error("unimplemented enable or priority bit is set");

	small_pkg_bits_a: assert property (
		!SMALL_PKG || (en[0][7] == 1'b0 && en[1][6] == 1'b0 && en[1][0] == 1'b0
			&& pr[0][7] == 1'b0 && pr[1][6] == 1'b0 && pr[1][0] == 1'b0))
		else $error("small package bit holds a one");

	write_en1_takes_a: assert property (
		wr_acc && paddr == PIE_OFF_EN1 |=> en[0] == ($past(pwdata[7:0]) & M1))
		else $error("enable word 1 did not take the write");

	write_en3_takes_a: assert property (
		wr_acc && paddr == PIE_OFF_EN3 |=> en[2] == $past(pwdata[7:0]))
		else $error("enable word 3 did not take the write");

	write_pr2_takes_a: assert property (
		wr_acc && paddr == PIE_OFF_PR2 |=> pr[1] == ($past(pwdata[7:0]) & M2))
		else $error("priority word 2 did not take the write");

	event_sets_flag_a: assert property (
		src_event[9] && M2[1] |=> fl[1][1])
		else $error("event on timer3 overflow did not set its flag");

	set_beats_clear_a: assert property (
		src_event[0] && wr_acc && paddr == PIE_OFF_FL1 && pwdata[0] |=> fl[0][0])
		else $error("clear of a flag lost a coinciding event");

	group_gate_a: assert property (
		!ctrl.priority_levels_enable && !ctrl.peripheral_group_enable
		|=> !irq_req.high && !irq_req.low)
		else $error("request passed with group enable clear");

	compat_no_low_a: assert property (
		!ctrl.priority_levels_enable |=> !irq_req.low)
		else $error("low level used with priority levels off");

	// built from the raw words so a slip in the act or prio wiring shows
	high_route_a: assert property (
		ctrl.priority_levels_enable && ctrl.global_irq_enable
		&& |({fl[2], fl[1], fl[0]} & {en[2], en[1], en[0]} & {pr[2], pr[1], pr[0]})
		|=> irq_req.high)
		else $error("high priority source did not raise the high level");

	low_route_a: assert property (
		ctrl.priority_levels_enable && ctrl.global_irq_enable
		&& ctrl.peripheral_group_enable
		&& |({fl[2], fl[1], fl[0]} & {en[2], en[1], en[0]} & ~{pr[2], pr[1], pr[0]})
		|=> irq_req.low)
		else $error("low priority source did not raise the low level");

	no_req_idle_a: assert property (
		act == 24'h000000 |=> !irq_req.high && !irq_req.low && !irq)
		else $error("request without an enabled pending flag");

	irq_level_a: assert property (
		|act |=> irq)
		else $error("summary interrupt did not follow pending flags");

	flag_hold_a: assert property (
		!(wr_acc && paddr == PIE_OFF_FL1) |=> (fl[0] & $past(fl[0])) == $past(fl[0]))
		else $error("flag dropped without a clear");

	read_data_a: assert property (
		setup && !pwrite && paddr == PIE_OFF_EN3
		|=> prdata == {24'h000000, $past(en[2])})
		else $error("read of enable word 3 returned wrong data");

	err_unmapped_a: assert property (
		psel && penable && !mapped(paddr)
		|-> pslverr ##1 $stable({en[2], en[1], en[0], pr[2], pr[1], pr[0], ctrl}))
		else $error("unmapped access not flagged or a register changed");

	after_reset_a: assert property (
		$rose(presetn) |-> en[2] == PIE_RST_EN3 && en[0] == PIE_RST_EN1
		&& pr[0] == (PIE_RST_PR & M1))
		else $error("reset value wrong");

	cover_high_c: cover property (irq_req.high && ctrl.priority_levels_enable);
	cover_low_c: cover property (irq_req.low);
	cover_compat_c: cover property (irq_req.high && !ctrl.priority_levels_enable);
	cover_clear_c: cover property (
		wr_acc && paddr == PIE_OFF_FL2 && |pwdata[7:0] ##1 fl[1] == 8'h00);
endmodule : pie_irq_unit
`default_nettype wire

// >>> tb/pie_src_model.sv
/*
 * Model of the peripheral flag sources on the far side of the bank.
 * Assumes the bench asks for events on trig, one pclk cycle at a time.
 */
`default_nettype none
module pie_src_model
	import pie_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [PIE_NSRC-1:0] trig,
	output logic [PIE_NSRC-1:0]       src_event
);
	timeunit 1ns;
	timeprecision 1ps;
	// peripherals launch one-cycle pulses from pclk, never a level
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			src_event <= '0;
		else
			src_event <= trig;
endmodule : pie_src_model
`default_nettype wire

// >>> tb/testbench.sv
/*
 * Self-checking bench of the interrupt enable and priority bank.
 * Assumes the zero-wait APB slave and two-edge request latency.
 */
`default_nettype none
module testbench;
	import pie_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [31:0] prdata_s, rd_s;
	logic pready, pslverr, irq, er;
	logic [PIE_NSRC-1:0] trig = '0, src_event;
	pie_req_s irq_req;
	int mismatches = 0, comparisons = 0, cyc = 0;
	pie_irq_unit #(.SMALL_PKG(1'b0)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.src_event(src_event), .irq_req(irq_req), .irq(irq));
	// second copy in the small package option shares the bus and the sources
	pie_irq_unit #(.SMALL_PKG(1'b1)) u_dut_small (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(), .prdata(prdata_s), .pslverr(),
		.src_event(src_event), .irq_req(), .irq());
	pie_src_model u_src (.pclk(pclk), .presetn(presetn), .trig(trig),
		.src_event(src_event));
	always #12.5 pclk = ~pclk;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// a hang costs a mismatch rather than a silent stall
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		rd_s = prdata_s;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic waitn(input int n);
		repeat (n) @(posedge pclk);
	endtask : waitn
	// event pulse, then time for flag and request to settle
	task automatic fire(input int k);
		@(posedge pclk);
		trig <= 24'h1 << k;
		@(posedge pclk);
		trig <= '0;
		waitn(4);
	endtask : fire
	task automatic t_regs;
		logic [7:0] a[6], r[6], w[6], rs[6], ws[6];
		a = '{PIE_OFF_EN1, PIE_OFF_EN2, PIE_OFF_EN3, PIE_OFF_PR1, PIE_OFF_PR2, PIE_OFF_PR3};
		r = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h5f, 8'hff};
		w = '{8'hff, 8'h5f, 8'hff, 8'hff, 8'h5f, 8'hff};
		rs = '{8'h00, 8'h00, 8'hff, 8'h7f, 8'h1e, 8'hff};
		ws = '{8'h7f, 8'h1e, 8'hff, 8'h7f, 8'h1e, 8'hff};
		foreach (a[i])
		begin
			apb(1'b0, a[i], '0);
			chk("reset value", {24'h0, r[i]}, rd);
			chk("small reset value", {24'h0, rs[i]}, rd_s);
			apb(1'b1, a[i], 32'h0000_00ff);
			apb(1'b0, a[i], '0);
			chk("write all ones", {24'h0, w[i]}, rd);
			chk("small write all ones", {24'h0, ws[i]}, rd_s);
			apb(1'b1, a[i], 32'h0000_0000);
			apb(1'b0, a[i], '0);
			chk("write zeros", 32'h0, rd);
			chk("small write zeros", 32'h0, rd_s);
		end
		apb(1'b0, 8'h40, '0);
		chk("unmapped error", 32'h1, {31'h0, er});
		apb(1'b1, 8'h40, 32'h0000_00ff);
		chk("unmapped write error", 32'h1, {31'h0, er});
		chk("ready", 32'h1, {31'h0, pready});
	endtask : t_regs
	task automatic t_flags;
		apb(1'b1, PIE_OFF_CTRL, 32'h7);
		fire(6);
		apb(1'b0, PIE_OFF_FL1, '0);
		chk("flag without enable", 32'h40, rd);
		chk("no request", 32'h0, {30'h0, irq_req});
		chk("irq masked", 32'h0, {31'h0, irq});
		fire(16);
		apb(1'b0, PIE_OFF_FL3, '0);
		chk("can flag", 32'h1, rd);
		apb(1'b1, PIE_OFF_FL3, 32'h1);
		apb(1'b1, PIE_OFF_FL1, 32'h40);
		apb(1'b0, PIE_OFF_FL1, '0);
		chk("flag cleared", 32'h0, rd);
		fire(9);
		apb(1'b0, PIE_OFF_FL2, '0);
		chk("timer3 flag", 32'h2, rd);
		apb(1'b1, PIE_OFF_FL2, 32'h2);
		apb(1'b0, PIE_OFF_FL2, '0);
		chk("timer3 flag cleared", 32'h0, rd);
		// event lands on the same edge as the access phase of the clear
		fork
			apb(1'b1, PIE_OFF_FL1, 32'h1);
			begin
				@(posedge pclk);
				trig <= 24'h1;
				@(posedge pclk);
				trig <= '0;
			end
		join
		apb(1'b0, PIE_OFF_FL1, '0);
		chk("set beats clear", 32'h1, rd);
		apb(1'b1, PIE_OFF_FL1, 32'h1);
		apb(1'b0, PIE_OFF_FL1, '0);
		chk("late clear", 32'h0, rd);
	endtask : t_flags
	task automatic t_steer;
		apb(1'b1, PIE_OFF_EN1, 32'h40);
		apb(1'b1, PIE_OFF_CTRL, 32'h4);
		fire(6);
		chk("irq raised", 32'h1, {31'h0, irq});
		chk("group off", 32'h0, {30'h0, irq_req});
		apb(1'b1, PIE_OFF_CTRL, 32'h6);
		waitn(2);
		chk("prio bit ignored", 32'h2, {30'h0, irq_req});
		apb(1'b1, PIE_OFF_CTRL, 32'h7);
		waitn(2);
		chk("low level", 32'h1, {30'h0, irq_req});
		apb(1'b1, PIE_OFF_PR1, 32'h40);
		waitn(2);
		chk("high level", 32'h2, {30'h0, irq_req});
		apb(1'b1, PIE_OFF_EN1, 32'h0);
		waitn(2);
		chk("enable off", 32'h0, {29'h0, irq, irq_req});
		apb(1'b1, PIE_OFF_EN1, 32'h40);
		apb(1'b1, PIE_OFF_FL1, 32'h40);
		waitn(2);
		chk("flag cleared", 32'h0, {29'h0, irq, irq_req});
	endtask : t_steer
	initial
	begin
		waitn(8);
		presetn <= 1'b1;
		t_regs();
		t_flags();
		t_steer();
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
